// ===== rcp_conv_model.sv
// converter stand-in: answers a conversion start with one raw sample; a new start before then restarts the count
`timescale 1ns/1ps
module rcp_conv_model
  import rcp_pkg::*;
#(
  parameter int LAT = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [RAW_W-1:0] sample,
  input wire logic sample_err,
  output logic conv_valid,
  output logic [RAW_W-1:0] converter_raw_reading,
  output logic conv_err
);
  int cnt_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
      conv_valid <= 1'b0;
      converter_raw_reading <= '0;
      conv_err <= 1'b0;
    end else begin
      conv_valid <= 1'b0;
      // data outside the valid cycle is garbage, so keep it moving
      converter_raw_reading <= ~converter_raw_reading;
      conv_err <= ~conv_err;
      if (start) begin
        cnt_q <= LAT;
      end else if (cnt_q > 0) begin
        cnt_q <= cnt_q - 1;
      end
      if (cnt_q == 1) begin
        conv_valid <= 1'b1;
        converter_raw_reading <= sample;
        conv_err <= sample_err;
      end
    end
  end
endmodule : rcp_conv_model

// ===== rcp_hs_format.sv
// packs a raw converter sample into the 3-byte high-speed reading word
`timescale 1ns/1ps
module rcp_hs_format
  import rcp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic valid_in,
  input wire logic [RAW_W-1:0] converter_raw_reading,
  input wire logic err_in,
  output logic [RESP_W-1:0] resp,
  output logic resp_valid
);
  typedef struct packed {
    logic [RESP_W-1:0] word;
    logic vld;
  } rcp_fmt_t;
  rcp_fmt_t st_q;
  rcp_fmt_t st_d;
  logic sgn;
  assign sgn = converter_raw_reading[RAW_W-1];
  always_comb begin
    st_d = st_q;
    st_d.vld = valid_in;
    if (valid_in) begin
      // two sign copies keep the 24-bit word a plain sign extension when err_in is low
      st_d.word = {sgn, sgn, sgn ^ err_in, converter_raw_reading};
    end
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign resp = st_q.word;
  assign resp_valid = st_q.vld;
  AST_FMT_SIGN: assert property (@(posedge mclk) disable iff (rst)
    valid_in |=> resp_valid && resp[23] == $past(sgn) && resp[22] == resp[23])
    else $error("sign bits do not follow the sample");
  AST_FMT_ERR: assert property (@(posedge mclk) disable iff (rst)
    valid_in |=> (resp[21] == (resp[23] ^ $past(err_in))))
    else $error("error bit not tied to sign and error");
endmodule : rcp_hs_format

// ===== rcp_parser.sv
// remote command string parser with Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module rcp_parser
  import rcp_pkg::*;
#(
  parameter int KEYS = 8,
  parameter logic [5:0] CMD_LIMIT = CMD_LEN_STD,
  parameter int unsigned QUIET_CYCLES = QUIET_CYC,
  parameter logic [3:0] SAMP_INIT = SAMP_DEFAULT
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  input wire logic remote_sw,
  input wire logic ext_trig,
  input wire logic [KEYS-1:0] panel_keys,
  input wire logic conv_valid,
  input wire logic [RAW_W-1:0] converter_raw_reading,
  input wire logic conv_err,
  input wire logic local_err,
  output logic remote_mode,
  output logic remote_locked,
  output logic hs_mode,
  output logic word16_mode,
  output logic [1:0] trig_mode,
  output logic fast_resistance_mode,
  output logic scaling_mode,
  output logic [3:0] samples_exp,
  output logic cmd_exec,
  output logic meas_trig,
  output logic hs_trig,
  output logic halt_pulse,
  output logic [RESP_W-1:0] hs_resp,
  output logic hs_resp_valid,
  output logic [KEYS-1:0] panel_keys_ok,
  output logic quiet_busy
);
  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic [6:0] last_char;
    logic [1:0] iface;
    logic external_pulse_trigger_alt;
    logic llo;
    logic remote;
    logic lock_remote;
    logic hs;
    logic hs_pend;
    logic word16;
    logic [1:0] trig;
    logic fast;
    logic scaling;
    logic high_avg;
    logic [3:0] samples;
    logic sv_fast;
    logic sv_cont;
    logic err_hold;
    logic ovf;
    logic [5:0] cnt;
    logic [QUIET_W-1:0] quiet;
    logic busy;
    logic [RESP_W-1:0] resp;
    logic resp_vld;
    logic exec_p;
    logic meas_p;
    logic hs_p;
    logic halt_p;
    logic [KEYS-1:0] keys_ok;
    logic sw_prev;
    logic et_prev;
  } rcp_st_t;

  localparam rcp_st_t ST_RST = '{waitreq: 1'b1, samples: SAMP_INIT, default: '0};
  localparam logic [QUIET_W-1:0] QUIET_LOAD = QUIET_CYCLES[QUIET_W-1:0];

  rcp_st_t st_q;
  rcp_st_t st_d;
  logic [KEYS+1:0] pins_s;
  logic [KEYS-1:0] keys_s;
  logic sw_s;
  logic et_s;
  logic [RESP_W-1:0] fmt_resp;
  logic fmt_vld;
  logic wr_acc;
  logic rd_acc;
  logic ch_wr;
  logic ch_ok;
  logic ch_recog;
  logic [6:0] ch;
  logic sw_rise;
  logic et_rise;
  logic [31:0] rd_mux;

  rcp_sync3 #(.W(KEYS + 2)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin({ext_trig, remote_sw, panel_keys}),
    .level(pins_s)
  );
  assign keys_s = pins_s[KEYS-1:0];
  assign sw_s = pins_s[KEYS];
  assign et_s = pins_s[KEYS+1];

  rcp_hs_format u_fmt (
    .mclk(mclk),
    .rst(rst),
    .valid_in(conv_valid),
    .converter_raw_reading(converter_raw_reading),
    .err_in(conv_err),
    .resp(fmt_resp),
    .resp_valid(fmt_vld)
  );

  // a write or read takes effect only at the edge where waitrequest is seen low
  assign wr_acc = avs_write && !st_q.waitreq;
  assign rd_acc = avs_read && !st_q.waitreq;
  assign ch = avs_writedata[6:0];
  assign ch_wr = wr_acc && avs_address == OFF_CHAR && avs_byteenable[0];
  // lower-case and control codes are not recognised and leave the mode alone
  assign ch_recog = ch >= CH_LOW && ch <= CH_HIGH;
  assign ch_ok = ch_wr && ch_recog && st_q.quiet == '0 && !st_q.lock_remote;
  assign sw_rise = sw_s && !st_q.sw_prev;
  assign et_rise = et_s && !st_q.et_prev;

  function automatic rcp_st_t go_local(rcp_st_t s);
    s.sv_fast = s.fast;
    s.sv_cont = s.trig[1];
    s.fast = 1'b0;
    s.trig[1] = 1'b0;
    s.scaling = 1'b0;
    if (s.high_avg) begin
      s.samples = SAMP_LOCAL;
      s.high_avg = 1'b0;
    end
    s.remote = 1'b0;
    s.hs = 1'b0;
    s.hs_pend = 1'b0;
    return s;
  endfunction : go_local

  function automatic rcp_st_t go_remote(rcp_st_t s);
    s.remote = 1'b1;
    s.fast = s.fast | s.sv_fast;
    s.trig[1] = s.trig[1] | s.sv_cont;
    s.sv_fast = 1'b0;
    s.sv_cont = 1'b0;
    return s;
  endfunction : go_remote

  always_comb begin
    rd_mux = '0;
    case (avs_address)
      OFF_CHAR: rd_mux[6:0] = st_q.last_char;
      OFF_CTRL: begin
        rd_mux[CTRL_IFACE_LSB+:2] = st_q.iface;
        rd_mux[CTRL_EXT_PULSE_TRIG_ALT] = st_q.external_pulse_trigger_alt;
        rd_mux[CTRL_LLO] = st_q.llo;
      end
      OFF_STATUS: begin
        rd_mux[ST_REMOTE] = st_q.remote;
        rd_mux[ST_LOCKED] = st_q.lock_remote;
        rd_mux[ST_HS] = st_q.hs;
        rd_mux[ST_W16] = st_q.word16;
        rd_mux[ST_QUIET] = st_q.quiet != '0;
        rd_mux[ST_HS_PEND] = st_q.hs_pend;
        rd_mux[ST_ERR_HOLD] = st_q.err_hold;
      end
      OFF_MODE: begin
        rd_mux[MD_TRIG_LSB+:2] = st_q.trig;
        rd_mux[MD_FAST] = st_q.fast;
        rd_mux[MD_SCALE] = st_q.scaling;
        rd_mux[MD_HAVG] = st_q.high_avg;
        rd_mux[MD_SAMP_LSB+:4] = st_q.samples;
      end
      OFF_RESP: begin
        rd_mux[RESP_W-1:0] = st_q.resp;
        rd_mux[RESP_VLD] = st_q.resp_vld;
      end
      OFF_CMD: begin
        rd_mux[5:0] = st_q.cnt;
        rd_mux[CMD_OVF] = st_q.ovf;
      end
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.exec_p = 1'b0;
    st_d.meas_p = 1'b0;
    st_d.hs_p = 1'b0;
    st_d.halt_p = 1'b0;
    st_d.waitreq = 1'b1;
    st_d.sw_prev = sw_s;
    st_d.et_prev = et_s;
    // every access is answered one cycle after it is raised
    if ((avs_read || avs_write) && st_q.waitreq) begin
      st_d.waitreq = 1'b0;
      st_d.rdata = rd_mux;
    end
    if (wr_acc && avs_byteenable[0]) begin
      case (avs_address)
        OFF_CTRL: begin
          st_d.iface = avs_writedata[CTRL_IFACE_LSB+:2];
          st_d.external_pulse_trigger_alt = avs_writedata[CTRL_EXT_PULSE_TRIG_ALT];
          st_d.llo = avs_writedata[CTRL_LLO];
        end
        OFF_MODE: begin
          st_d.trig = avs_writedata[MD_TRIG_LSB+:2];
          st_d.fast = avs_writedata[MD_FAST];
          st_d.scaling = avs_writedata[MD_SCALE];
          st_d.high_avg = avs_writedata[MD_HAVG];
        end
        default: ;
      endcase
    end
    // overflow and error-held flags sit in byte lane one
    if (wr_acc && avs_byteenable[1]) begin
      case (avs_address)
        OFF_CMD: if (avs_writedata[CMD_OVF]) st_d.ovf = 1'b0;
        OFF_STATUS: if (avs_writedata[ST_ERR_HOLD]) st_d.err_hold = 1'b0;
        OFF_MODE: st_d.samples = avs_writedata[MD_SAMP_LSB+:4];
        default: ;
      endcase
    end
    if (rd_acc && avs_address == OFF_RESP) begin
      st_d.resp_vld = 1'b0;
    end
    if (st_q.quiet != '0) begin
      st_d.quiet = st_q.quiet - 1'b1;
    end
    if (ch_ok) begin
      st_d.last_char = ch;
      if (st_q.hs && ch != CH_TRIG) begin
        st_d.hs = 1'b0;
        st_d.hs_pend = 1'b0;
      end else begin
        if (!st_q.remote) begin
          st_d = go_remote(st_d);
        end
        case (ch)
          CH_RESET: begin
            st_d = ST_RST;
            st_d.iface = st_q.iface;
            st_d.sw_prev = sw_s;
            st_d.et_prev = et_s;
            st_d.quiet = QUIET_LOAD;
          end
          CH_HALT: begin
            st_d.trig[1] = 1'b0;
            st_d.halt_p = 1'b1;
            st_d.hs = 1'b0;
            st_d.hs_pend = 1'b0;
          end
          CH_LOCAL: begin
            if (st_q.iface != IF_BUS) begin
              st_d = go_local(st_d);
              st_d.lock_remote = 1'b1;
            end
          end
          CH_HS: begin
            st_d.hs = 1'b1;
            st_d.hs_p = 1'b1;
            st_d.hs_pend = 1'b1;
          end
          CH_TOGGLE: st_d.word16 = !st_q.word16;
          CH_TRIG: begin
            if (st_q.hs) begin
              if (!st_q.hs_pend) begin
                st_d.hs_p = 1'b1;
                st_d.hs_pend = 1'b1;
              end
            end else begin
              st_d.exec_p = 1'b1;
              st_d.meas_p = 1'b1;
              st_d.cnt = '0;
            end
          end
          CH_EXEC: begin
            st_d.exec_p = 1'b1;
            st_d.cnt = '0;
          end
          default: begin
            if (st_q.cnt < CMD_LIMIT) begin
              st_d.cnt = st_q.cnt + 1'b1;
            end else begin
              st_d.ovf = 1'b1;
            end
          end
        endcase
      end
    end
    if (sw_rise && !st_q.llo) begin
      if (st_q.remote) begin
        st_d = go_local(st_d);
      end else if (st_q.iface != IF_BUS) begin
        st_d = go_remote(st_d);
        st_d.lock_remote = 1'b0;
      end
    end
    if (et_rise && st_q.external_pulse_trigger_alt && st_d.hs && !st_d.hs_pend) begin
      st_d.hs_p = 1'b1;
      st_d.hs_pend = 1'b1;
    end
    // a new reading beats a read-clear in the same cycle
    if (fmt_vld && st_d.hs_pend) begin
      st_d.resp = fmt_resp;
      st_d.resp_vld = 1'b1;
      st_d.hs_pend = 1'b0;
    end
    if (local_err && !st_q.remote) begin
      st_d.err_hold = 1'b1;
    end
    st_d.keys_ok = st_q.remote ? '0 : keys_s;
    st_d.busy = st_d.quiet != '0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_waitrequest = st_q.waitreq;
  assign avs_readdata = st_q.rdata;
  assign remote_mode = st_q.remote;
  assign remote_locked = st_q.lock_remote;
  assign hs_mode = st_q.hs;
  assign word16_mode = st_q.word16;
  assign trig_mode = st_q.trig;
  assign fast_resistance_mode = st_q.fast;
  assign scaling_mode = st_q.scaling;
  assign samples_exp = st_q.samples;
  assign cmd_exec = st_q.exec_p;
  assign meas_trig = st_q.meas_p;
  assign hs_trig = st_q.hs_p;
  assign halt_pulse = st_q.halt_p;
  assign hs_resp = st_q.resp;
  assign hs_resp_valid = st_q.resp_vld;
  assign panel_keys_ok = st_q.keys_ok;
  assign quiet_busy = st_q.busy;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_REMOTE_ON_CHAR: assert property (ch_ok && !st_q.hs && !sw_rise && ch != CH_RESET && ch != CH_LOCAL
    |=> remote_mode)
    else $error("recognised character did not enter remote");
  AST_RESET_DEFAULTS: assert property (ch_ok && !st_q.hs && ch == CH_RESET
    |=> !remote_mode && !word16_mode && quiet_busy && st_q.cnt == '0)
    else $error("reset character did not restore defaults");
  AST_QUIET_DROP: assert property (ch_wr && st_q.quiet > 1 |=> $stable(st_q.cnt) && $stable(st_q.last_char))
    else $error("character taken during quiet interval");
  AST_HS_EXIT: assert property (ch_ok && st_q.hs && ch != CH_TRIG
    |=> !hs_mode && !cmd_exec && !meas_trig && $stable(st_q.cnt) && $stable(word16_mode))
    else $error("non-trigger character did more than exit high-speed mode");
  AST_HS_ENTER: assert property (ch_ok && !st_q.hs && ch == CH_HS && !sw_rise |=> hs_mode && hs_trig)
    else $error("exclamation did not start a high-speed reading");
  AST_TOGGLE: assert property (ch_ok && !st_q.hs && ch == CH_TOGGLE |=> word16_mode != $past(word16_mode))
    else $error("slash did not toggle word mode");
  AST_KEYS_BLOCK: assert property (remote_mode |=> panel_keys_ok == '0)
    else $error("panel key passed while remote");
  AST_LOCAL_DROP: assert property ($fell(remote_mode) |-> !fast_resistance_mode && !scaling_mode && !trig_mode[1])
    else $error("fast resistance or scaling kept after going local");
  AST_BUS_SW: assert property (sw_rise && !st_q.remote && st_q.iface == IF_BUS && !ch_ok |=> !remote_mode)
    else $error("remote switch entered remote on bus interface");
  AST_TRIG_EXEC: assert property (ch_ok && !st_q.hs && ch == CH_TRIG |=> cmd_exec && meas_trig ##1 !cmd_exec)
    else $error("question mark did not execute and trigger once");
endmodule : rcp_parser

// ===== rcp_parser_test.sv
// self-checking bench for the remote command string parser
`timescale 1ns/1ps
module rcp_parser_test;
  import rcp_pkg::*;
  localparam int LIMIT = 20000;
  localparam logic [6:0] CH_V = 7'h56;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest;
  logic [31:0] avs_readdata;
  logic remote_sw = 1'b0;
  logic ext_trig = 1'b0;
  logic [7:0] panel_keys = 8'hFF;
  logic local_err = 1'b0;
  logic [RAW_W-1:0] sample = 21'h0ABCDE;
  logic sample_err = 1'b0;
  logic conv_valid;
  logic conv_err;
  logic [RAW_W-1:0] converter_raw_reading;
  logic remote_mode, remote_locked, hs_mode, word16_mode, fast_resistance_mode, scaling_mode;
  logic cmd_exec, meas_trig, hs_trig, halt_pulse, hs_resp_valid, quiet_busy;
  logic [1:0] trig_mode;
  logic [3:0] samples_exp;
  logic [RESP_W-1:0] hs_resp;
  logic [7:0] panel_keys_ok;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_exec = 0;
  int n_meas = 0;
  int n_halt = 0;
  int n_hs = 0;

  rcp_parser #(.QUIET_CYCLES(20)) uut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .remote_sw(remote_sw), .ext_trig(ext_trig),
    .panel_keys(panel_keys), .conv_valid(conv_valid), .converter_raw_reading(converter_raw_reading),
    .conv_err(conv_err), .local_err(local_err), .remote_mode(remote_mode), .remote_locked(remote_locked),
    .hs_mode(hs_mode), .word16_mode(word16_mode), .trig_mode(trig_mode),
    .fast_resistance_mode(fast_resistance_mode), .scaling_mode(scaling_mode), .samples_exp(samples_exp),
    .cmd_exec(cmd_exec), .meas_trig(meas_trig), .hs_trig(hs_trig), .halt_pulse(halt_pulse), .hs_resp(hs_resp),
    .hs_resp_valid(hs_resp_valid), .panel_keys_ok(panel_keys_ok), .quiet_busy(quiet_busy));

  rcp_conv_model conv (.mclk(mclk), .rst(rst), .start(hs_trig), .sample(sample), .sample_err(sample_err),
    .conv_valid(conv_valid), .converter_raw_reading(converter_raw_reading), .conv_err(conv_err));

  always #2 mclk = ~mclk;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // pulses are counted here so no single-cycle output is missed
  always @(posedge mclk) begin
    cycles++;
    if (cmd_exec === 1'b1) n_exec++;
    if (meas_trig === 1'b1) n_meas++;
    if (halt_pulse === 1'b1) n_halt++;
    if (hs_trig === 1'b1) n_hs++;
    if (cycles == LIMIT) begin
      mismatches++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  // values read right after the edge are the ones sampled at that edge
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask : bus_read

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus_read(a, d);
    chk(d, exp, what);
  endtask : rd_chk

  task automatic send(input logic [6:0] ch);
    bus_write(OFF_CHAR, {25'h0, ch});
    tick(2);
  endtask : send

  task automatic press();
    @(posedge mclk);
    remote_sw <= 1'b1;
    repeat (8) @(posedge mclk);
    remote_sw <= 1'b0;
    tick(8);
  endtask : press

  task automatic wait_resp();
    for (int i = 0; i < 50 && hs_resp_valid !== 1'b1; i++) tick(1);
  endtask : wait_resp

  initial begin
    logic [31:0] d;
    int e0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    tick(2);
    rd_chk(OFF_STATUS, 32'h0, "status after reset");
    rd_chk(OFF_MODE, 32'h0000_0500, "mode after reset");
    rd_chk(5'h18, 32'h0, "unmapped read");
    $display("test reset done");
    chk(panel_keys_ok, 8'hFF, "keys live in local");
    send(CH_V);
    chk(remote_mode, 1, "char enters remote");
    tick(8);
    chk(panel_keys_ok, 8'h00, "keys ignored in remote");
    send(CH_TOGGLE);
    chk(word16_mode, 1, "toggle to 16 bit");
    send(CH_TOGGLE);
    chk(word16_mode, 0, "toggle back to 8 bit");
    $display("test remote entry done");
    bus_write(OFF_CTRL, 32'h6);
    e0 = n_hs;
    send(CH_HS);
    chk(hs_mode, 1, "high-speed entered");
    chk(n_hs - e0, 1, "first reading triggered");
    wait_resp();
    chk(hs_resp, 24'h0ABCDE, "positive reading");
    rd_chk(OFF_RESP, 32'h800A_BCDE, "response word");
    @(posedge mclk);
    sample <= 21'h1F0001;
    sample_err <= 1'b1;
    send(CH_TRIG);
    wait_resp();
    chk(hs_resp, 24'hDF0001, "negative reading in error");
    bus_read(OFF_RESP, d);
    @(posedge mclk);
    ext_trig <= 1'b1;
    repeat (8) @(posedge mclk);
    ext_trig <= 1'b0;
    wait_resp();
    chk(hs_resp_valid, 1, "pulse triggers reading");
    bus_read(OFF_CMD, d);
    send(CH_V);
    chk(hs_mode, 0, "other char leaves high-speed");
    rd_chk(OFF_CMD, d, "char not queued");
    $display("test high-speed done");
    bus_write(OFF_MODE, 32'h0000_0503);
    e0 = n_halt;
    send(CH_HALT);
    chk(trig_mode, 2'b01, "continuous becomes single");
    chk(n_halt - e0, 1, "halt pulse");
    $display("test halt done");
    e0 = n_exec;
    send(CH_EXEC);
    chk(n_exec - e0, 1, "execute pulse");
    rd_chk(OFF_CMD, 32'h0, "queue empty after execute");
    repeat (32) send(CH_V);
    rd_chk(OFF_CMD, 32'h11F, "overflow at limit");
    e0 = n_meas;
    send(CH_TRIG);
    chk(n_meas - e0, 1, "trigger reads once");
    bus_write(OFF_CMD, 32'h100);
    rd_chk(OFF_CMD, 32'h0, "overflow cleared by write");
    $display("test command string done");
    bus_write(OFF_CTRL, 32'h1);
    bus_write(OFF_MODE, 32'h0000_051E);
    send(CH_LOCAL);
    chk({remote_mode, remote_locked}, 2'b01, "local and locked");
    chk({fast_resistance_mode, scaling_mode}, 2'b00, "fast and scaling dropped");
    chk(samples_exp, SAMP_LOCAL, "high average becomes 2^7");
    send(CH_V);
    chk(remote_mode, 0, "locked interface ignores char");
    @(posedge mclk);
    local_err <= 1'b1;
    @(posedge mclk);
    local_err <= 1'b0;
    press();
    chk(remote_mode, 1, "switch returns remote");
    chk({fast_resistance_mode, trig_mode[1]}, 2'b11, "modes resumed");
    rd_chk(OFF_STATUS, 32'h101, "local error kept");
    bus_write(OFF_STATUS, 32'h100);
    rd_chk(OFF_STATUS, 32'h1, "error hold cleared by write");
    $display("test go local done");
    bus_write(OFF_CTRL, 32'h0);
    press();
    chk(remote_mode, 0, "bus switch goes local");
    press();
    chk(remote_mode, 0, "bus switch never goes remote");
    send(CH_V);
    bus_write(OFF_CTRL, 32'h8);
    press();
    chk(remote_mode, 1, "lockout blocks switch");
    $display("test remote switch done");
    send(CH_RESET);
    chk(quiet_busy, 1, "quiet interval runs");
    chk({remote_mode, trig_mode, samples_exp}, {3'b000, SAMP_DEFAULT}, "defaults restored");
    send(CH_V);
    chk(remote_mode, 0, "char dropped while quiet");
    for (int i = 0; i < 100 && quiet_busy !== 1'b0; i++) tick(1);
    send(CH_V);
    chk(remote_mode, 1, "char accepted after quiet");
    rd_chk(OFF_CMD, 32'h1, "queue starts empty");
    $display("test reset char done");
    final_report();
  end
endmodule : rcp_parser_test

// ===== rcp_pkg.sv
// constants shared by the remote command string parser
package rcp_pkg;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CHAR = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_MODE = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_RESP = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_CMD = 5'h14;
  localparam int CTRL_IFACE_LSB = 0;
  localparam int CTRL_EXT_PULSE_TRIG_ALT = 2;
  localparam int CTRL_LLO = 3;
  localparam int ST_REMOTE = 0;
  localparam int ST_LOCKED = 1;
  localparam int ST_HS = 2;
  localparam int ST_W16 = 3;
  localparam int ST_QUIET = 4;
  localparam int ST_HS_PEND = 5;
  localparam int ST_ERR_HOLD = 8;
  localparam int MD_TRIG_LSB = 0;
  localparam int MD_FAST = 2;
  localparam int MD_SCALE = 3;
  localparam int MD_HAVG = 4;
  localparam int MD_SAMP_LSB = 8;
  localparam int RESP_VLD = 31;
  localparam int CMD_OVF = 8;
  localparam logic [1:0] IF_BUS = 2'h0;
  localparam logic [1:0] IF_SERIAL = 2'h1;
  localparam logic [1:0] IF_PARALLEL = 2'h2;
  localparam logic [6:0] CH_RESET = 7'h2A;
  localparam logic [6:0] CH_HALT = 7'h25;
  localparam logic [6:0] CH_LOCAL = 7'h23;
  localparam logic [6:0] CH_HS = 7'h21;
  localparam logic [6:0] CH_TOGGLE = 7'h2F;
  localparam logic [6:0] CH_TRIG = 7'h3F;
  localparam logic [6:0] CH_EXEC = 7'h2C;
  localparam logic [6:0] CH_LOW = 7'h20;
  localparam logic [6:0] CH_HIGH = 7'h5F;
  localparam logic [5:0] CMD_LEN_STD = 6'h1F;
  localparam logic [5:0] CMD_LEN_EXT = 6'h3B;
  localparam logic [3:0] SAMP_LOCAL = 4'h7;
  localparam logic [3:0] SAMP_DEFAULT = 4'h5;
  localparam int CLK_MHZ = 250;
  localparam int QUIET_MS = 3000;
  localparam int QUIET_ALT_MS = 2000;
  localparam int unsigned QUIET_CYC = QUIET_MS * 1000 * CLK_MHZ;
  localparam int QUIET_W = 30;
  localparam int RAW_W = 21;
  localparam int RESP_W = 24;
endpackage : rcp_pkg

// ===== rcp_sync3.sv
// three-flop pin synchroniser, output moves once stages two and three agree
`timescale 1ns/1ps
module rcp_sync3 #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } rcp_sync_t;
  rcp_sync_t st_q;
  rcp_sync_t st_d;
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.lvl = ((st_q.s2 ~^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.lvl);
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign level = st_q.lvl;
endmodule : rcp_sync3
